// ### core/nand_host_regs.svh
// Constants for the NAND host pin controller: command codes and timing.
// Assumes a 40 MHz clock; included by bare name.
`ifndef NAND_HOST_REGS_SVH
`define NAND_HOST_REGS_SVH

`define CLK_PERIOD_NS 25
`define CMD_READ_SETUP 8'h00
`define CMD_READ_EXEC 8'h30
`define CMD_PROG_SETUP 8'h80
`define CMD_PROG_EXEC 8'h10
`define CMD_ERASE_SETUP 8'h60
`define CMD_ERASE_EXEC 8'hD0
`define CMD_RESET 8'hFF
`define CMD_STATUS 8'h70
// Strobe phase times in ns; low and high phase of each strobe
`define STROBE_LOW_NS 25
`define STROBE_HIGH_NS 25
`define STROBE_LOW_CYC ((`STROBE_LOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STROBE_HIGH_CYC ((`STROBE_HIGH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Page read serial access least cycle
`define READ_CYCLE_NS 25
`define READ_CYCLE_CYC ((`READ_CYCLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Typical program and erase times, used only as documentation of busy length
`define PROG_TIME_NS 200000
`define ERASE_TIME_NS 1500000
// Wait after an execute command before ready/busy is trusted
`define BUSY_SETTLE_NS 100
`define BUSY_SETTLE_CYC ((`BUSY_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Address layout
`define COL_BITS 12
`define ROW_BITS 18
`define ADDR_BITS 30
`define COL_BYTES 3'd2
`define ROW_BYTES 3'd3
`define PAGE_BYTES 2112

`endif

// ### core/nand_host_pkg.sv
// Types for the NAND host pin controller.
// Assumes the constants header sits alongside.
package nand_host_pkg;
    typedef enum logic [1:0] {
        OP_READ = 2'b00,
        OP_PROGRAM = 2'b01,
        OP_ERASE = 2'b10,
        OP_SINGLE = 2'b11
    } op_t;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0000,
        ST_CMD1 = 4'b0001,
        ST_ADDR = 4'b0010,
        ST_DATAIN = 4'b0011,
        ST_CMD2 = 4'b0100,
        ST_SETTLE = 4'b0101,
        ST_BUSY = 4'b0110,
        ST_DATAOUT = 4'b0111,
        ST_STATUS = 4'b1000,
        ST_DONE = 4'b1001
    } state_t;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_WRITE = 2'b01,
        BUS_READ = 2'b10
    } bus_t;
endpackage

// ### core/nand_strobe_cycle.sv
// One pin cycle on the NAND bus: a write-strobe or read-strobe pulse.
// Assumes the caller holds latch selects steady while busy is high.
`timescale 1ns/1ps
`include "nand_host_regs.svh"

module nand_strobe_cycle (
    input wire logic clk,
    input wire logic rstn,
    input wire logic start,
    input wire logic isRead,
    input wire logic [7:0] wrByte,
    input wire logic [7:0] padIn,
    output logic busy,
    output logic done,
    output logic writeStrobeN,
    output logic outputStrobeN,
    output logic [7:0] padOut,
    output logic padOe,
    output logic [7:0] rdByte
);
    logic [3:0] count;
    logic lowPhase;
    logic readCycle;
    logic [7:0] sync1;
    logic [7:0] sync2;
    wire logic lastLow = (count == 4'(`STROBE_LOW_CYC - 1));
    // Read cycles stay high one extra clock so the two-flop pad sample
    // already holds the new byte when done is raised
    wire logic lastHigh = readCycle ? (count == 4'(`STROBE_HIGH_CYC)) :
        (count == 4'(`STROBE_HIGH_CYC - 1));
    wire logic finish = busy && !lowPhase && lastHigh;

    // Strobe timing: low phase then high phase
    always_ff @(posedge clk) begin
        if (!rstn) begin
            busy <= 1'b0;
            lowPhase <= 1'b0;
            count <= 4'h0;
            readCycle <= 1'b0;
            padOut <= 8'h00;
        end else if (start && !busy) begin
            busy <= 1'b1;
            lowPhase <= 1'b1;
            count <= 4'h0;
            readCycle <= isRead;
            padOut <= wrByte;
        end else if (busy && lowPhase && lastLow) begin
            lowPhase <= 1'b0;
            count <= 4'h0;
        end else if (finish) begin
            busy <= 1'b0;
        end else if (busy) begin
            count <= count + 4'h1;
        end
    end

    // Pad sampling through two flops; the second flop is the read byte
    always_ff @(posedge clk) begin
        if (!rstn) begin
            sync1 <= 8'h00;
            sync2 <= 8'h00;
        end else begin
            sync1 <= padIn;
            sync2 <= sync1;
        end
    end
    assign rdByte = sync2;

    // Byte taken by the device on the rising write edge
    assign writeStrobeN = !(busy && lowPhase && !readCycle);
    // Falling read edge advances the device column
    assign outputStrobeN = !(busy && lowPhase && readCycle);
    // Host drives the bus only on write cycles
    assign padOe = busy && !readCycle;
    assign done = finish;
endmodule

// ### core/nand_host_pin_interface.sv
// Host controller that drives a NAND flash through its pins.
// Assumes the pad ring merges padOut/padOe with the device's drive.
`timescale 1ns/1ps
`include "nand_host_regs.svh"

module nand_host_pin_interface (
    input wire logic clk,
    input wire logic rstn,
    input wire logic reqValid,
    output logic reqReady,
    input wire nand_host_pkg::op_t reqOp,
    input wire logic [7:0] reqSingleCmd,
    input wire logic [29:0] reqAddr,
    input wire logic [11:0] reqLength,
    input wire logic allowWrite,
    input wire logic [7:0] wrData,
    output logic wrDataReady,
    output logic [7:0] rdData,
    output logic rdValid,
    output logic opDone,
    output logic [7:0] statusByte,
    output logic chipSelectN,
    output logic cmdLatch,
    output logic addrLatch,
    output logic writeStrobeN,
    output logic output_strobe_n,
    output logic writeProtectN,
    input wire logic [7:0] shared_byte_bus_in,
    output logic [7:0] shared_byte_bus_out,
    output logic shared_byte_bus_oe,
    input wire logic readyBusyN
);
    nand_host_pkg::state_t state;
    nand_host_pkg::op_t op;
    logic [7:0] singleCmd;
    logic [29:0] addr;
    logic [11:0] length;
    logic [11:0] index;
    logic [2:0] addrIdx;
    logic [2:0] settle;
    logic writeOk;
    logic rbSync1;
    logic rbSync2;
    logic cycStart;
    logic cycRead;
    logic [7:0] cycByte;
    logic cycBusy;
    logic cycDone;
    logic [7:0] cycRd;

    // Address byte by position, unused bits low
    function automatic logic [7:0] addrByte(input logic [29:0] a,
                                            input logic [2:0] n);
        case (n)
            3'd0: addrByte = a[7:0];
            3'd1: addrByte = {4'h0, a[11:8]};
            3'd2: addrByte = a[19:12];
            3'd3: addrByte = a[27:20];
            3'd4: addrByte = {6'h00, a[29:28]};
            default: addrByte = 8'h00;
        endcase
    endfunction

    // Ready/busy pin synchronised before use
    always_ff @(posedge clk) begin
        if (!rstn) begin
            rbSync1 <= 1'b0;
            rbSync2 <= 1'b0;
        end else begin
            rbSync1 <= readyBusyN;
            rbSync2 <= rbSync1;
        end
    end
    wire logic devReady = rbSync2;

    // Setup and execute codes per operation
    wire logic [7:0] setupCode =
        (op == nand_host_pkg::OP_READ) ? `CMD_READ_SETUP :
        (op == nand_host_pkg::OP_PROGRAM) ? `CMD_PROG_SETUP :
        (op == nand_host_pkg::OP_ERASE) ? `CMD_ERASE_SETUP : singleCmd;
    wire logic [7:0] execCode =
        (op == nand_host_pkg::OP_READ) ? `CMD_READ_EXEC :
        (op == nand_host_pkg::OP_PROGRAM) ? `CMD_PROG_EXEC : `CMD_ERASE_EXEC;
    // Erase skips the two column bytes
    wire logic [2:0] firstAddr = (op == nand_host_pkg::OP_ERASE) ?
        `COL_BYTES : 3'd0;
    wire logic [2:0] lastAddr = `COL_BYTES + `ROW_BYTES - 3'd1;
    // Reset and status go out even while the device is busy
    wire logic cmdAnytime = (reqSingleCmd == `CMD_RESET) ||
        (reqSingleCmd == `CMD_STATUS);
    // Other requests wait for ready
    wire logic canAccept = (state == nand_host_pkg::ST_IDLE) &&
        (devReady || (reqOp == nand_host_pkg::OP_SINGLE && cmdAnytime));
    wire logic lastByte = (index == length - 12'h1);

    // Pin cycle request, selects and data
    assign cycStart = !cycBusy && !cycDone && (
        state == nand_host_pkg::ST_CMD1 || state == nand_host_pkg::ST_ADDR ||
        state == nand_host_pkg::ST_CMD2 || state == nand_host_pkg::ST_STATUS ||
        state == nand_host_pkg::ST_DATAIN ||
        state == nand_host_pkg::ST_DATAOUT);
    assign cycRead = (state == nand_host_pkg::ST_DATAOUT) ||
        (state == nand_host_pkg::ST_STATUS);
    assign cycByte =
        (state == nand_host_pkg::ST_CMD1) ? setupCode :
        (state == nand_host_pkg::ST_CMD2) ? execCode :
        (state == nand_host_pkg::ST_ADDR) ? addrByte(addr, addrIdx) : wrData;
    assign wrDataReady = (state == nand_host_pkg::ST_DATAIN) && cycDone;

    nand_strobe_cycle strobe (
        .clk(clk),
        .rstn(rstn),
        .start(cycStart),
        .isRead(cycRead),
        .wrByte(cycByte),
        .padIn(shared_byte_bus_in),
        .busy(cycBusy),
        .done(cycDone),
        .writeStrobeN(writeStrobeN),
        .outputStrobeN(output_strobe_n),
        .padOut(shared_byte_bus_out),
        .padOe(shared_byte_bus_oe),
        .rdByte(cycRd)
    );

    // Sequencer over command, address, data and busy phases
    always_ff @(posedge clk) begin
        if (!rstn) begin
            state <= nand_host_pkg::ST_IDLE;
            op <= nand_host_pkg::OP_SINGLE;
            singleCmd <= 8'h00;
            addr <= 30'h0;
            length <= 12'h0;
            index <= 12'h0;
            addrIdx <= 3'd0;
            settle <= 3'd0;
            writeOk <= 1'b0;
            statusByte <= 8'h00;
        end else begin
            case (state)
                nand_host_pkg::ST_IDLE: begin
                    if (reqValid && canAccept) begin
                        op <= reqOp;
                        singleCmd <= reqSingleCmd;
                        addr <= reqAddr;
                        length <= (reqLength == 12'h0) ? 12'h1 : reqLength;
                        writeOk <= allowWrite;
                        index <= 12'h0;
                        state <= nand_host_pkg::ST_CMD1;
                    end
                end
                nand_host_pkg::ST_CMD1: begin
                    if (cycDone) begin
                        addrIdx <= firstAddr;
                        if (op != nand_host_pkg::OP_SINGLE)
                            state <= nand_host_pkg::ST_ADDR;
                        else if (singleCmd == `CMD_STATUS)
                            state <= nand_host_pkg::ST_STATUS;
                        else
                            state <= nand_host_pkg::ST_SETTLE;
                        settle <= 3'd0;
                    end
                end
                nand_host_pkg::ST_ADDR: begin
                    if (cycDone) begin
                        addrIdx <= addrIdx + 3'd1;
                        if (addrIdx == lastAddr) begin
                            if (op == nand_host_pkg::OP_PROGRAM)
                                state <= nand_host_pkg::ST_DATAIN;
                            else
                                state <= nand_host_pkg::ST_CMD2;
                        end
                    end
                end
                nand_host_pkg::ST_DATAIN: begin
                    if (cycDone) begin
                        index <= index + 12'h1;
                        if (lastByte)
                            state <= nand_host_pkg::ST_CMD2;
                    end
                end
                nand_host_pkg::ST_CMD2: begin
                    if (cycDone) begin
                        settle <= 3'd0;
                        state <= nand_host_pkg::ST_SETTLE;
                    end
                end
                nand_host_pkg::ST_SETTLE: begin
                    // Give ready/busy time to fall
                    settle <= settle + 3'd1;
                    if (settle == 3'(`BUSY_SETTLE_CYC + 2))
                        state <= nand_host_pkg::ST_BUSY;
                end
                nand_host_pkg::ST_BUSY: begin
                    // Device runs the operation alone
                    if (devReady) begin
                        index <= 12'h0;
                        if (op == nand_host_pkg::OP_READ)
                            state <= nand_host_pkg::ST_DATAOUT;
                        else
                            state <= nand_host_pkg::ST_DONE;
                    end
                end
                nand_host_pkg::ST_DATAOUT: begin
                    // One byte per read cycle from the page
                    if (cycDone) begin
                        index <= index + 12'h1;
                        if (lastByte)
                            state <= nand_host_pkg::ST_DONE;
                    end
                end
                nand_host_pkg::ST_STATUS: begin
                    if (cycDone) begin
                        statusByte <= cycRd;
                        state <= nand_host_pkg::ST_DONE;
                    end
                end
                nand_host_pkg::ST_DONE: begin
                    writeOk <= 1'b0;
                    state <= nand_host_pkg::ST_IDLE;
                end
                default: state <= nand_host_pkg::ST_IDLE;
            endcase
        end
    end

    // Read data strobe out of the pin cycle
    always_ff @(posedge clk) begin
        if (!rstn) begin
            rdData <= 8'h00;
            rdValid <= 1'b0;
        end else begin
            rdValid <= cycDone && (state == nand_host_pkg::ST_DATAOUT);
            if (cycDone && state == nand_host_pkg::ST_DATAOUT)
                rdData <= cycRd;
        end
    end

    // Latch selects steer each write strobe
    assign cmdLatch = (state == nand_host_pkg::ST_CMD1) ||
        (state == nand_host_pkg::ST_CMD2);
    assign addrLatch = (state == nand_host_pkg::ST_ADDR);
    // Chip select held through busy; device ignores deselect anyway
    assign chipSelectN = (state == nand_host_pkg::ST_IDLE);
    // Protect stays low unless the current request set allowWrite
    assign writeProtectN = writeOk && (state != nand_host_pkg::ST_IDLE);
    assign reqReady = canAccept;
    assign opDone = (state == nand_host_pkg::ST_DONE);
endmodule

// ### sim/nand_host_checker_sva.sv
// Pin-level checker for the NAND host controller.
// Assumes binding to the controller top; sees only its ports.
`timescale 1ns/1ps
module nand_host_checker (
    input wire logic clk,
    input wire logic rstn,
    input wire logic chipSelectN,
    input wire logic cmdLatch,
    input wire logic addrLatch,
    input wire logic writeStrobeN,
    input wire logic output_strobe_n,
    input wire logic writeProtectN,
    input wire logic [7:0] shared_byte_bus_out,
    input wire logic shared_byte_bus_oe,
    input wire logic readyBusyN,
    input wire logic rdValid,
    input wire logic wrDataReady,
    input wire logic opDone
);
    logic [2:0] addrIdx;
    logic eraseOp;
    wire wrLow = !writeStrobeN;
    wire isExec = cmdLatch && wrLow && shared_byte_bus_out inside
        {8'h30, 8'h10, 8'hD0};
    wire [2:0] addrPos = addrIdx + (eraseOp ? 3'h2 : 3'h0);

    // Count address bytes since the last command byte
    always_ff @(posedge clk) begin
        if (!rstn) begin
            addrIdx <= 3'h0;
            eraseOp <= 1'b0;
        end else if (wrLow && cmdLatch) begin
            addrIdx <= 3'h0;
            eraseOp <= shared_byte_bus_out == 8'h60;
        end else if (wrLow && addrLatch) begin
            addrIdx <= addrIdx + 3'h1;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    a_strobes_apart: assert property (!(wrLow && !output_strobe_n))
        else $error("both strobes low");
    a_latch_selected: assert property ((cmdLatch || addrLatch) |-> !chipSelectN)
        else $error("latch while deselected");
    a_latch_exclusive: assert property (!(cmdLatch && addrLatch))
        else $error("both latches high");
    a_write_pulse: assert property ($fell(writeStrobeN) |=> writeStrobeN)
        else $error("write strobe width");
    a_byte_held: assert property ($rose(writeStrobeN) |->
        shared_byte_bus_oe && $stable(shared_byte_bus_out))
        else $error("byte moved at write edge");
    a_read_bus_free: assert property (!output_strobe_n |-> !shared_byte_bus_oe)
        else $error("host drives during read");
    a_read_cycle: assert property ($fell(output_strobe_n) |=> output_strobe_n[*2])
        else $error("read strobe cycle short");
    a_protect_idle: assert property (chipSelectN |-> !writeProtectN)
        else $error("protect released while idle");
    a_addr_pad_low: assert property (addrLatch && wrLow |->
        (addrPos != 3'h1 || shared_byte_bus_out[7:4] == 4'h0) &&
        (addrPos != 3'h4 || shared_byte_bus_out[7:2] == 6'h00))
        else $error("unused address bits set");
    a_addr_count: assert property (isExec |->
        addrIdx == (eraseOp ? 3'h3 : 3'h5))
        else $error("wrong address byte count");
    a_busy_cmd_only: assert property (cmdLatch && wrLow && !readyBusyN |->
        shared_byte_bus_out inside {8'hFF, 8'h70})
        else $error("command sent while busy");

    c_read_byte: cover property (rdValid);
    c_write_byte: cover property (wrDataReady);
    c_done_busy: cover property ($rose(readyBusyN) ##[1:40] opDone);
endmodule

bind nand_host_pin_interface nand_host_checker i_checker (.*);

// ### sim/nand_device_model.sv
// Behavioural flash device model on the far side of the host pins.
// Assumes the bench resolves the byte bus and the ready/busy pull-up.
`timescale 1ns/1ps
module nand_device_model #(
    parameter int BUSY_NS = 2000,
    parameter logic [7:0] READY_STATUS = 8'hE0,
    parameter logic [7:0] BUSY_STATUS = 8'hA0
) (
    input wire logic chipSelectN,
    input wire logic cmdLatch,
    input wire logic addrLatch,
    input wire logic writeStrobeN,
    input wire logic output_strobe_n,
    input wire logic writeProtectN,
    input wire logic [7:0] busLevel,
    output logic [7:0] devData,
    output logic rbLow
);
    logic [7:0] cmdLog[$];
    logic [7:0] addrLog[$];
    logic [7:0] dataLog[$];
    logic [7:0] lastCmd = 8'h00;
    logic [11:0] column = 12'h000;
    logic statusMode = 1'b0;
    int addrSeen = 0;
    int busyCount = 0;

    initial begin
        devData = 8'h00;
        rbLow = 1'b0;
    end

    // Busy window runs regardless of chip select
    task automatic start_busy();
        fork
            begin
                rbLow = 1'b1;
                busyCount++;
                #(BUSY_NS) rbLow = 1'b0;
            end
        join_none
    endtask

    // Latch command, address or data on the rising write edge
    always @(posedge writeStrobeN) begin
        if (!chipSelectN && cmdLatch) begin
            cmdLog.push_back(busLevel);
            lastCmd = busLevel;
            addrSeen = 0;
            statusMode = busLevel == 8'h70;
            if (busLevel inside {8'h30, 8'hFF} ||
                (busLevel inside {8'h10, 8'hD0} && writeProtectN))
                start_busy();
        end else if (!chipSelectN && addrLatch) begin
            if (addrSeen < (lastCmd == 8'h60 ? 3 : 5))
                addrLog.push_back(busLevel);
            if (addrSeen == 0)
                column[7:0] = busLevel;
            if (addrSeen == 1)
                column[11:8] = busLevel[3:0];
            addrSeen++;
        end else if (!chipSelectN) begin
            dataLog.push_back(busLevel);
        end
    end

    // Serial read out, column advances on each falling read edge outside status mode
    always @(negedge output_strobe_n) begin
        if (!chipSelectN) begin
            devData = statusMode ? (rbLow ? BUSY_STATUS : READY_STATUS)
                : column[7:0] ^ 8'h5A;
            if (!statusMode)
                column = column + 12'h001;
        end
    end

    // Released bus shows the inverse of its last value
    always @(posedge chipSelectN or posedge cmdLatch) begin
        devData = ~devData;
    end
endmodule

// ### sim/tb_top.sv
// Self-checking bench for the NAND host pin controller.
// Assumes the device model and checker files compile before it.
`timescale 1ns/1ps
module tb_top;
    logic clk, rstn, reqValid, allowWrite;
    nand_host_pkg::op_t reqOp;
    logic [7:0] reqSingleCmd, wrData, rdData, statusByte, busOut, devData;
    logic [29:0] reqAddr;
    logic [11:0] reqLength;
    logic reqReady, wrDataReady, rdValid, opDone, chipSelectN, cmdLatch;
    logic addrLatch, writeStrobeN, output_strobe_n, writeProtectN;
    logic busOe, rbLow;
    logic [7:0] rdBuf[$];
    int fails = 0;
    int checks_done = 0;
    wire logic [7:0] busLevel = busOe ? busOut : devData;
    wire logic readyBusyN = rbLow ? 1'b0 : 1'b1;

    nand_host_pin_interface i_nand_host_pin_interface (.clk(clk),
        .rstn(rstn), .reqValid(reqValid), .reqReady(reqReady),
        .reqOp(reqOp), .reqSingleCmd(reqSingleCmd), .reqAddr(reqAddr),
        .reqLength(reqLength), .allowWrite(allowWrite), .wrData(wrData),
        .wrDataReady(wrDataReady), .rdData(rdData), .rdValid(rdValid),
        .opDone(opDone), .statusByte(statusByte),
        .chipSelectN(chipSelectN), .cmdLatch(cmdLatch),
        .addrLatch(addrLatch), .writeStrobeN(writeStrobeN),
        .output_strobe_n(output_strobe_n), .writeProtectN(writeProtectN),
        .shared_byte_bus_in(busLevel), .shared_byte_bus_out(busOut),
        .shared_byte_bus_oe(busOe), .readyBusyN(readyBusyN));
    nand_device_model i_nand_device_model (.chipSelectN(chipSelectN),
        .cmdLatch(cmdLatch), .addrLatch(addrLatch),
        .writeStrobeN(writeStrobeN), .output_strobe_n(output_strobe_n),
        .writeProtectN(writeProtectN), .busLevel(busLevel),
        .devData(devData), .rbLow(rbLow));

    task automatic stop_test();
        if (fails == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic check8(input string what, input logic [7:0] exp,
        input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            $display("mismatch %s expected %h seen %h", what, exp, got);
            fails++;
        end
    endtask

    // One request, collecting read bytes and feeding program bytes
    task automatic run_op(input nand_host_pkg::op_t op, input logic [7:0] cmd,
        input logic [29:0] addr, input logic [11:0] len, input logic aw);
        int n;
        logic feed;
        n = 0;
        feed = 1'b0;
        rdBuf = {};
        i_nand_device_model.cmdLog = {};
        i_nand_device_model.addrLog = {};
        i_nand_device_model.dataLog = {};
        @(posedge clk);
        reqValid <= 1'b1;
        reqOp <= op;
        reqSingleCmd <= cmd;
        reqAddr <= addr;
        reqLength <= len;
        allowWrite <= aw;
        wrData <= 8'hC0;
        do begin
            @(negedge clk);
            n++;
        end while (reqReady !== 1'b1 && n < 4000);
        @(posedge clk);
        reqValid <= 1'b0;
        do begin
            @(posedge clk);
            if (feed)
                wrData <= wrData + 8'h01;
            @(negedge clk);
            feed = wrDataReady === 1'b1;
            if (rdValid === 1'b1)
                rdBuf.push_back(rdData);
            n++;
        end while (opDone !== 1'b1 && n < 4000);
        if (n >= 4000) begin
            fails++;
            stop_test();
        end
    endtask

    // Command pair and address bytes as seen by the device
    task automatic check_log(input logic [7:0] c0, input logic [7:0] c1,
        input logic [29:0] a, input int nA);
        logic [7:0] ab[5];
        ab = '{a[7:0], {4'h0, a[11:8]}, a[19:12], a[27:20], {6'h00, a[29:28]}};
        check8("cmd0", c0, i_nand_device_model.cmdLog[0]);
        check8("cmd1", c1, i_nand_device_model.cmdLog[1]);
        check8("addrCount", 8'(nA), 8'(i_nand_device_model.addrLog.size()));
        for (int i = 0; i < nA; i++)
            check8("addr", ab[5 - nA + i], i_nand_device_model.addrLog[i]);
    endtask

    task automatic t_idle();
        check8("idlePins", 8'h0B, {4'h0, chipSelectN, writeProtectN,
            writeStrobeN, output_strobe_n});
        check8("idleOe", 8'h00, {7'h00, busOe});
    endtask

    task automatic t_read();
        int b;
        b = i_nand_device_model.busyCount;
        run_op(nand_host_pkg::OP_READ, 8'h00, 30'h3A5C383D, 12'h003, 1'b0);
        check_log(8'h00, 8'h30, 30'h3A5C383D, 5);
        check8("rdCount", 8'h03, 8'(rdBuf.size()));
        for (int i = 0; i < 3; i++)
            check8("rdData", 8'h3D + 8'(i) ^ 8'h5A, rdBuf[i]);
        check8("readBusy", 8'(b + 1), 8'(i_nand_device_model.busyCount));
    endtask

    task automatic t_program(input logic aw);
        int b;
        b = i_nand_device_model.busyCount;
        run_op(nand_host_pkg::OP_PROGRAM, 8'h00, 30'h00001000, 12'h002, aw);
        check_log(8'h80, 8'h10, 30'h00001000, 5);
        check8("dataCount", 8'h02, 8'(i_nand_device_model.dataLog.size()));
        check8("data0", 8'hC0, i_nand_device_model.dataLog[0]);
        check8("data1", 8'hC1, i_nand_device_model.dataLog[1]);
        check8("progBusy", 8'(b + aw), 8'(i_nand_device_model.busyCount));
    endtask

    task automatic t_erase();
        run_op(nand_host_pkg::OP_ERASE, 8'h00, 30'h3FFFF123, 12'h001, 1'b1);
        check_log(8'h60, 8'hD0, 30'h3FFFF123, 3);
    endtask

    task automatic t_single();
        run_op(nand_host_pkg::OP_SINGLE, 8'h70, 30'h0, 12'h001, 1'b0);
        check8("statusCmd", 8'h70, i_nand_device_model.cmdLog[0]);
        check8("status", 8'hE0, statusByte);
        run_op(nand_host_pkg::OP_SINGLE, 8'hFF, 30'h0, 12'h001, 1'b0);
        check8("resetCmd", 8'hFF, i_nand_device_model.cmdLog[0]);
        check8("readyAfter", 8'h01, {7'h00, readyBusyN});
    endtask

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    initial begin
        rstn = 1'b0;
        reqValid = 1'b0;
        reqOp = nand_host_pkg::OP_READ;
        reqSingleCmd = 8'h00;
        reqAddr = 30'h0;
        reqLength = 12'h001;
        allowWrite = 1'b0;
        wrData = 8'h00;
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        @(negedge clk);
        t_idle();
        t_program(1'b1);
        t_read();
        t_program(1'b0);
        t_erase();
        t_single();
        stop_test();
    end
endmodule
